// file: bench/uart_line_modem_input_flags_logic_tb_top.sv
// self-checking bench of the line and modem_input_flags logic
`timescale 1ns/1ps
module uart_line_modem_input_flags_logic_tb_top;
  import ulm_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, cs = 1'b0, wrEn = 1'b0, rdEn = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wrData = 8'h00;
  logic [7:0] rdData;
  logic serialInPin, serialOutPin, rtsN, dtrN, auxOutputAN, auxOutputBN, rxDataIrq;
  logic ctsN = 1'b1, dsrN = 1'b1, riN = 1'b1, dcdN = 1'b1;
  logic [7:0] lcr, d, s;
  logic [11:0] b, got;
  logic [3:0] pn, o, m;
  logic [7:0] q[$];
  int n, k, lvl, cycles, miscompares, comparisons;
  always #10 clk = ~clk;
  ulm_uart #(.RX_DEPTH(32)) ulm_uart_inst (.clk(clk), .rst_n(rst_n), .cs(cs), .addr(addr), .wrEn(wrEn),
    .rdEn(rdEn), .wrData(wrData), .rdData(rdData), .serialInPin(serialInPin), .serialOutPin(serialOutPin),
    .ctsN(ctsN), .dsrN(dsrN), .riN(riN), .dcdN(dcdN), .rtsN(rtsN), .dtrN(dtrN), .auxOutputAN(auxOutputAN),
    .auxOutputBN(auxOutputBN), .rxDataIrq(rxDataIrq));
  ulm_remote_term ulm_remote_term_inst (.clk(clk), .lineFromDut(serialOutPin), .lineToDut(serialInPin));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      miscompares++;
      end_of_test();
    end
  end
  // each access leaves one idle edge so the next one never re-raises a strobe in the same step
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    cs = 1'b1;
    addr = a;
    wrEn = 1'b1;
    wrData = v;
    @(posedge clk);
    #1;
    cs = 1'b0;
    wrEn = 1'b0;
    @(posedge clk);
    #1;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    cs = 1'b1;
    addr = a;
    rdEn = 1'b1;
    @(posedge clk);
    #1;
    cs = 1'b0;
    rdEn = 1'b0;
    v = rdData;
    @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [11:0] g, input logic [11:0] e, input logic [11:0] mk, input string w);
    comparisons++;
    if ((g & mk) !== (e & mk)) begin
      miscompares++;
      $display("[FAIL] %0t %s got %h exp %h", $time, w, g, e);
    end
  endtask
  task automatic rdc(input logic [2:0] a, input logic [7:0] e, input logic [7:0] mk, input string w);
    logic [7:0] v;
    rd(a, v);
    chk(v, e, mk, w);
  endtask
  function automatic logic [7:0] dmask(input logic [7:0] f);
    return 8'hff >> (3 - f[1:0]);
  endfunction
  // start, data lsb first, parity, one stop bit
  function automatic int frame(input logic [7:0] f, input logic [7:0] v, output logic [11:0] fb);
    int nb;
    logic [7:0] dm;
    nb = 5 + int'(f[1:0]);
    dm = v & dmask(f);
    fb = '1;
    fb[0] = 1'b0;
    for (int i = 0; i < nb; i++) fb[1 + i] = dm[i];
    if (f[3]) fb[1 + nb] = f[5] ? ~f[4] : (^dm) ~^ f[4];
    return 2 + nb + int'(f[3]);
  endfunction
  task automatic rxByte(input logic [7:0] f, input bit keep);
    logic [7:0] v;
    logic [11:0] fb;
    int c;
    v = 8'($urandom);
    c = frame(f, v, fb);
    ulm_remote_term_inst.send(fb, c);
    repeat (2) @(posedge clk);
    #1;
    if (keep) q.push_back(v & dmask(f));
  endtask
  task automatic sendErr(input logic [7:0] f, input bit stopBad, input logic [7:0] e);
    logic [7:0] v;
    logic [11:0] fb;
    int c;
    v = 8'($urandom) | 8'h01;
    c = frame(f, v, fb);
    if (stopBad) fb[c - 1] = 1'b0;
    else fb[c - 2] = ~fb[c - 2];
    ulm_remote_term_inst.send(fb, c);
    repeat (2) @(posedge clk);
    #1;
    rdc(ADR_LSR, e, 8'hff, "error flags");
    rdc(ADR_LSR, 8'h00, 8'h9e, "flags cleared");
    rdc(ADR_DATA, v, 8'hff, "error data");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    s = 8'($urandom(38));
    repeat (12) @(posedge clk);
    #1;
    rst_n = 1'b1;
    chk({serialOutPin, rtsN, dtrN, auxOutputAN, auxOutputBN}, 12'h1f, 12'h1f, "reset pins");
    rdc(ADR_LCR, 8'h00, 8'hff, "lcr reset");
    rdc(ADR_MCR, 8'h00, 8'hff, "mcr reset");
    rdc(ADR_LSR, 8'h60, 8'hff, "lsr reset");
    rdc(ADR_MSR, 8'h00, 8'hff, "msr reset");
    rdc(ADR_IIR, 8'h01, 8'hff, "iir reset");
    d = 8'($urandom);
    wr(ADR_SCR, d);
    rdc(ADR_SCR, d, 8'hff, "scratch");
    wr(ADR_IER, 8'h0f);
    wr(ADR_LCR, 8'h80);
    wr(ADR_DATA, 8'h08);
    wr(ADR_IER, 8'h00);
    rdc(ADR_DATA, 8'h08, 8'hff, "divisor lo");
    rdc(ADR_IER, 8'h00, 8'hff, "divisor hi");
    wr(ADR_LCR, 8'h03);
    rdc(ADR_IER, 8'h0f, 8'hff, "ier");
    $display("registers done");
    for (int i = 0; i < 4; i++) begin
      m = 4'($urandom);
      wr(ADR_MCR, {4'h0, m});
      rdc(ADR_MCR, {4'h0, m}, 8'h1f, "mcr");
      chk({auxOutputBN, auxOutputAN, rtsN, dtrN}, {8'h0, ~m}, 12'hf, "modem pins");
    end
    wr(ADR_MCR, 8'h1f);
    wr(ADR_DATA, 8'h5a);
    chk({rtsN, dtrN, auxOutputAN, auxOutputBN}, 12'hf, 12'hf, "loop pins");
    rdc(ADR_MSR, 8'hf0, 8'hf0, "loop msr");
    repeat (100) @(posedge clk);
    #1;
    rdc(ADR_DATA, 8'h5a, 8'hff, "loop data");
    wr(ADR_MCR, 8'h08);
    repeat (3) @(posedge clk);
    #1;
    rd(ADR_MSR, s);
    o = 4'hf;
    for (int i = 0; i < 8; i++) begin
      pn = 4'($urandom);
      {dcdN, riN, dsrN, ctsN} = pn;
      repeat (3) @(posedge clk);
      #1;
      rdc(ADR_MSR, {~pn, pn[3] ^ o[3], pn[2] & ~o[2], pn[1] ^ o[1], pn[0] ^ o[0]}, 8'hff, "msr");
      o = pn;
    end
    $display("modem done");
    for (int f = 0; f < 64; f++) begin
      lcr = 8'(f);
      wr(ADR_LCR, lcr);
      d = 8'($urandom);
      n = frame(lcr, d, b);
      fork
        ulm_remote_term_inst.capture(n, got);
        begin
          // write then read back to back, chip select held, so the status is seen before the load
          cs = 1'b1;
          addr = ADR_DATA;
          wrData = d;
          wrEn = 1'b1;
          @(posedge clk);
          #1;
          wrEn = 1'b0;
          rdEn = 1'b1;
          addr = ADR_LSR;
          @(posedge clk);
          #1;
          cs = 1'b0;
          rdEn = 1'b0;
          chk(rdData, 12'h000, 12'h060, "tx busy");
          @(posedge clk);
          #1;
        end
      join
      chk(got, b, 12'hfff >> (12 - n), "tx frame");
      k = 0;
      do begin
        rd(ADR_LSR, s);
        k++;
      end while (s[6] !== 1'b1 && k < 40);
      chk(s, 8'h60, 8'h60, "tx idle");
      ulm_remote_term_inst.send(b, n);
      repeat (2) @(posedge clk);
      #1;
      rdc(ADR_LSR, 8'h61, 8'h7f, "rx status");
      rdc(ADR_DATA, d & dmask(lcr), 8'hff, "rx data");
      rdc(ADR_LSR, 8'h00, 8'h01, "rx empty");
    end
    $display("formats done");
    wr(ADR_LCR, 8'h43);
    wr(ADR_DATA, 8'hff);
    for (int i = 0; i < 40; i++) begin
      @(posedge clk);
      #1;
      chk(serialOutPin, 12'h0, 12'h1, "break out");
    end
    wr(ADR_LCR, 8'h1b);
    repeat (100) @(posedge clk);
    #1;
    sendErr(8'h1b, 1'b0, 8'h65);
    sendErr(8'h1b, 1'b1, 8'h69);
    q.delete();
    rxByte(8'h1b, 1'b1);
    rxByte(8'h1b, 1'b0);
    rdc(ADR_LSR, 8'h63, 8'h7f, "char overrun");
    rdc(ADR_DATA, q.pop_front(), 8'hff, "kept char");
    $display("char errors done");
    wr(ADR_IER, 8'h01);
    for (int t = 0; t < 4; t++) begin
      lvl = (t == 0) ? 1 : (t == 1) ? 4 : (t == 2) ? 8 : 14;
      wr(ADR_IIR, {2'(t), 6'h03});
      q.delete();
      for (int i = 1; i <= lvl; i++) begin
        rxByte(8'h1b, 1'b1);
        chk(rxDataIrq, i >= lvl, 12'h1, "trigger irq");
      end
      rdc(ADR_IIR, 8'hc4, 8'hcf, "iir data");
      rdc(ADR_DATA, q.pop_front(), 8'hff, "fifo head");
      @(posedge clk);
      #1;
      chk(rxDataIrq, 12'h0, 12'h1, "irq drop");
    end
    wr(ADR_IIR, 8'h03);
    q.delete();
    for (int i = 0; i < 33; i++) begin
      rxByte(8'h1b, i < 32);
    end
    rdc(ADR_LSR, 8'h03, 8'h03, "fifo overrun");
    while (q.size() > 0) begin
      rdc(ADR_DATA, q.pop_front(), 8'hff, "drain");
    end
    rdc(ADR_LSR, 8'h00, 8'h01, "fifo empty");
    sendErr(8'h1b, 1'b1, 8'he9);
    wr(ADR_LCR, 8'h00);
    ulm_remote_term_inst.send(12'h000, 12);
    repeat (2) @(posedge clk);
    #1;
    rdc(ADR_LSR, 8'h11, 8'h11, "break seen");
    rdc(ADR_DATA, 8'h00, 8'hff, "break char");
    rdc(ADR_LSR, 8'h00, 8'h01, "one break char");
    wr(ADR_IIR, 8'h00);
    rdc(ADR_LSR, 8'h00, 8'h80, "char mode fifo_rx_error");
    $display("fifo done");
    end_of_test();
  end
endmodule

// file: bench/ulm_remote_term.sv
// remote serial terminal model on the line side of the channel
`timescale 1ns/1ps
module ulm_remote_term (
  input wire logic clk,
  input wire logic lineFromDut,
  output logic lineToDut
);
  int bitCycles = 8;
  initial begin
    lineToDut = 1'b1;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // frame bits sent lsb first, line back to mark after the last one
  task automatic send(input logic [11:0] bits, input int n);
    for (int i = 0; i < n; i++) begin
      lineToDut = bits[i];
      repeat (bitCycles) @(posedge clk);
      #1;
    end
    lineToDut = 1'b1;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // samples n bits mid-bit, start bit first
  task automatic capture(input int n, output logic [11:0] bits);
    bits = '1;
    @(negedge lineFromDut);
    repeat (bitCycles / 2) @(posedge clk);
    #1;
    for (int i = 0; i < n; i++) begin
      bits[i] = lineFromDut;
      repeat (bitCycles) @(posedge clk);
      #1;
    end
  endtask
endmodule

// file: hw/ulm_pkg.sv
// constants for the serial channel line and modem_input_flags logic
package ulm_pkg;
  localparam logic [2:0] ADR_DATA = 3'h0;
  localparam logic [2:0] ADR_IER = 3'h1;
  localparam logic [2:0] ADR_IIR = 3'h2;
  localparam logic [2:0] ADR_LCR = 3'h3;
  localparam logic [2:0] ADR_MCR = 3'h4;
  localparam logic [2:0] ADR_LSR = 3'h5;
  localparam logic [2:0] ADR_MSR = 3'h6;
  localparam logic [2:0] ADR_SCR = 3'h7;
  localparam int LCR_DIVISOR_ACCESS_SELECT = 7;
  localparam int LCR_BRK = 6;
  localparam int LCR_STK = 5;
  localparam int LCR_EPS = 4;
  localparam int LCR_PEN = 3;
  localparam int LCR_STB = 2;
  localparam int MCR_LOOP = 4;
  localparam int MCR_AUX_OUTPUT_B = 3;
  localparam int MCR_AUX_OUTPUT_A = 2;
  localparam int MCR_RTS = 1;
  localparam int MCR_DTR = 0;
  localparam int FCR_EN = 0;
  localparam int FCR_RXRST = 1;
  localparam int FCR_TRIG = 6;
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [15:0] RST_DIV = 16'h0002;
  localparam logic [5:0] TRIG_0 = 6'h01;
  localparam logic [5:0] TRIG_1 = 6'h04;
  localparam logic [5:0] TRIG_2 = 6'h08;
  localparam logic [5:0] TRIG_3 = 6'h0e;
  localparam logic [2:0] STOP_HALF_1 = 3'h2;
  localparam logic [2:0] STOP_HALF_15 = 3'h3;
  localparam logic [2:0] STOP_HALF_2 = 3'h4;
endpackage

// file: hw/ulm_uart.sv
// receive fifo and the line, modem and register logic of one serial channel
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module ulm_fifo #(
  parameter int W = 11,
  parameter int D = 32,
  localparam int AW = $clog2(D)
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clr,
  input wire logic inValid,
  output logic inReady,
  input wire logic [W-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [W-1:0] outData,
  output logic [AW:0] count
);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0] cnt_r;
  wire doPush = inValid && inReady;
  wire doPop = outValid && outReady;
  assign inReady = cnt_r != D[AW:0];
  assign outValid = cnt_r != '0;
  assign outData = mem[rp_r];
  assign count = cnt_r;
  always_ff @(posedge clk) begin
    if (doPush) begin
      mem[wp_r] <= inData;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else if (clr) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (doPush) wp_r <= wp_r + 1'b1;
      if (doPop) rp_r <= rp_r + 1'b1;
      cnt_r <= cnt_r + {{AW{1'b0}}, doPush} - {{AW{1'b0}}, doPop};
    end
  end
endmodule
////////////////////////////////////////////////////////////////////////////////
// How it works
// - divisor select high maps low addresses to divisor latches, else data and enable
// - break force holds serial output at space
// - parity off sends none; even choice selects odd or even
// - forced parity sends constant, inverse of even choice
// - word length codes give five to eight data bits
// - stop count gives one, one and a half, or two stop bits
// - loopback joins transmitter to receiver, modem outputs to inputs, pins inactive except serial output held at space by break force
// - modem_output_control bits drive their pins inverted
// - fifo error flag zero in character mode, else set when an error character is queued, cleared on status read
// - transmitter empty only when holding and shift registers both empty
// - holding empty set when holding register free, cleared by write
// - error flags clear on status read; parity, framing and break shown when character reaches head
// - break flag when input spaced for a whole word time
// - break loads one zero character, then waits for mark and start
// - framing error on spaced stop bit, parity error on mismatch
// - character mode overrun when new character arrives before read
// - fifo mode overrun when full, new character destroyed
// - data ready while buffer or fifo holds a character
// - modem_input_flags bits are complements of input pins
// - delta bits set on change, ring only on rising input, clear on read
// - fifo data interrupt follows fill against trigger level
// - trigger code selects 1, 4, 8 or 14 bytes
module ulm_uart #(
  parameter int RX_DEPTH = 32
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cs,
  input wire logic [2:0] addr,
  input wire logic wrEn,
  input wire logic rdEn,
  input wire logic [7:0] wrData,
  output logic [7:0] rdData,
  input wire logic serialInPin,
  output logic serialOutPin,
  input wire logic ctsN,
  input wire logic dsrN,
  input wire logic riN,
  input wire logic dcdN,
  output logic rtsN,
  output logic dtrN,
  output logic auxOutputAN,
  output logic auxOutputBN,
  output logic rxDataIrq
);
  import ulm_pkg::*;
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} ulm_tx_t;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP, RX_MARK} ulm_rx_t;
  localparam int CW = $clog2(RX_DEPTH) + 1;
  logic [7:0] lcr_r, mcr_r, scr_r, thr_r, txSh_r, rxSh_r, rdData_r;
  logic [3:0] ier_r, msrPrev_r;
  logic [15:0] div_r, txCnt_r, rxCnt_r;
  logic fifoMode_r, thrFull_r, txPar_r, rxPar_r, rxZero_r, serialOut_r;
  logic [1:0] trigSel_r;
  logic [2:0] txBit_r, txHalf_r, rxBit_r;
  logic rxHalf_r, oe_r, pe_r, fe_r, bi_r, fifo_rx_error_r, headRep_r;
  logic clear_to_send_change_r, set_ready_change_r, ring_trailing_edge_r, carrier_change_r, rtsN_r, dtrN_r, auxA_r, auxB_r, irq_r;
  ulm_tx_t txSt_r;
  ulm_rx_t rxSt_r;
  logic inReady, outValid;
  logic [10:0] head;
  logic [CW-1:0] fifoCount;
////////////////////////////////////////////////////////////////////////////////
  // register decode
  wire wrS = cs && wrEn;
  wire rdS = cs && rdEn;
  wire divisor_access_select = lcr_r[LCR_DIVISOR_ACCESS_SELECT];
  wire selLo = addr == ADR_DATA;
  wire selHi = addr == ADR_IER;
  wire dllWr = wrS && selLo && divisor_access_select;
  wire dlmWr = wrS && selHi && divisor_access_select;
  wire thrWr = wrS && selLo && !divisor_access_select;
  wire ierWr = wrS && selHi && !divisor_access_select;
  wire fcrWr = wrS && addr == ADR_IIR;
  wire rbrRd = rdS && selLo && !divisor_access_select;
  wire lsrRd = rdS && addr == ADR_LSR;
  wire msrRd = rdS && addr == ADR_MSR;
  wire loop = mcr_r[MCR_LOOP];
  wire parity_on = lcr_r[LCR_PEN];
  wire even_parity_choice = lcr_r[LCR_EPS];
  wire stk = lcr_r[LCR_STK];
  wire [1:0] wls = lcr_r[1:0];
  wire [2:0] lastBit = {1'b1, wls};
  wire [7:0] dataMask = 8'hff >> (2'd3 - wls);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lcr_r <= RST_REG;
      mcr_r <= RST_REG;
      scr_r <= RST_REG;
      ier_r <= RST_REG[3:0];
      div_r <= RST_DIV;
      fifoMode_r <= 1'b0;
      trigSel_r <= 2'b00;
    end else begin
      if (dllWr) div_r[7:0] <= wrData;
      if (dlmWr) div_r[15:8] <= wrData;
      if (ierWr) ier_r <= wrData[3:0];
      if (wrS && addr == ADR_LCR) lcr_r <= wrData;
      if (wrS && addr == ADR_MCR) mcr_r <= {3'b000, wrData[4:0]};
      if (wrS && addr == ADR_SCR) scr_r <= wrData;
      if (fcrWr) fifoMode_r <= wrData[FCR_EN];
      if (fcrWr && wrData[FCR_EN]) trigSel_r <= wrData[FCR_TRIG+:2];
    end
  end
////////////////////////////////////////////////////////////////////////////////
  // half-bit timing
  wire [15:0] halfDiv = (div_r[15:1] == 15'h0000) ? 16'h0001 : {1'b0, div_r[15:1]};
  wire txTick = txCnt_r == halfDiv - 16'h0001;
  wire rxTick = rxCnt_r == halfDiv - 16'h0001;
  wire [2:0] stopHalves = !lcr_r[LCR_STB] ? STOP_HALF_1 :
    (wls == 2'b00 ? STOP_HALF_15 : STOP_HALF_2);
////////////////////////////////////////////////////////////////////////////////
  // transmitter
  wire txLoad = txSt_r == TX_IDLE && thrFull_r && !thrWr;
  wire [7:0] txMasked = thr_r & dataMask;
  wire txParNew = stk ? !even_parity_choice : (even_parity_choice ? ^txMasked : ~^txMasked);
  wire txEnd = txTick && (txSt_r == TX_STOP ? txHalf_r == stopHalves - 3'h1 : txHalf_r[0]);
  wire txLine = txSt_r == TX_START ? 1'b0 : txSt_r == TX_DATA ? txSh_r[0] :
    txSt_r == TX_PAR ? txPar_r : 1'b1;
  wire tx_all_empty = !thrFull_r && txSt_r == TX_IDLE;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      txSt_r <= TX_IDLE;
      thr_r <= RST_REG;
      thrFull_r <= 1'b0;
      txSh_r <= RST_REG;
      txPar_r <= 1'b0;
      txBit_r <= 3'h0;
      txHalf_r <= 3'h0;
      txCnt_r <= 16'h0000;
    end else begin
      if (thrWr) thr_r <= wrData;
      if (thrWr) thrFull_r <= 1'b1;
      else if (txLoad) thrFull_r <= 1'b0;
      txCnt_r <= (txTick || txLoad) ? 16'h0000 : txCnt_r + 16'h0001;
      if (txLoad) begin
        txSt_r <= TX_START;
        txSh_r <= txMasked;
        txPar_r <= txParNew;
        txHalf_r <= 3'h0;
      end else if (txTick) begin
        txHalf_r <= txEnd ? 3'h0 : txHalf_r + 3'h1;
      end
      if (txEnd) begin
        unique case (txSt_r)
          TX_START: begin
            txSt_r <= TX_DATA;
            txBit_r <= 3'h0;
          end
          TX_DATA: begin
            txSh_r <= {1'b0, txSh_r[7:1]};
            txBit_r <= txBit_r + 3'h1;
            if (txBit_r == lastBit) txSt_r <= parity_on ? TX_PAR : TX_STOP;
          end
          TX_PAR: txSt_r <= TX_STOP;
          TX_STOP: txSt_r <= TX_IDLE;
          TX_IDLE: txSt_r <= TX_IDLE;
        endcase
      end
    end
  end
////////////////////////////////////////////////////////////////////////////////
  // receiver
  wire rxIn = loop ? txLine : serialInPin;
  wire rxSmp = rxTick && rxHalf_r;
  wire rxDone = rxSt_r == RX_STOP && rxSmp;
  wire [7:0] rxData = rxSh_r >> (2'd3 - wls);
  wire rxParExp = stk ? !even_parity_choice : (even_parity_choice ? ^rxData : ~^rxData);
  wire rxBreak = rxZero_r && !rxIn;
  wire [10:0] rxEntry = {rxBreak, !rxIn, parity_on && rxPar_r != rxParExp, rxData};
  wire rxOvr = fifoMode_r ? !inReady : fifoCount != '0;
  wire rxPush = rxDone && !rxOvr;
  wire fifoClr = fcrWr && (!wrData[FCR_EN] || wrData[FCR_RXRST]);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rxSt_r <= RX_IDLE;
      rxSh_r <= RST_REG;
      rxBit_r <= 3'h0;
      rxHalf_r <= 1'b0;
      rxCnt_r <= 16'h0000;
      rxPar_r <= 1'b0;
      rxZero_r <= 1'b0;
    end else begin
      rxCnt_r <= (rxTick || rxSt_r == RX_IDLE) ? 16'h0000 : rxCnt_r + 16'h0001;
      if (rxTick) rxHalf_r <= !rxHalf_r;
      unique case (rxSt_r)
        RX_IDLE: if (!rxIn) begin
          rxSt_r <= RX_START;
          rxHalf_r <= 1'b0;
        end
        RX_START: if (rxTick) begin
          rxSt_r <= rxIn ? RX_IDLE : RX_DATA;
          rxHalf_r <= 1'b0;
          rxBit_r <= 3'h0;
          rxZero_r <= 1'b1;
        end
        RX_DATA: if (rxSmp) begin
          rxSh_r <= {rxIn, rxSh_r[7:1]};
          rxZero_r <= rxZero_r && !rxIn;
          rxBit_r <= rxBit_r + 3'h1;
          if (rxBit_r == lastBit) rxSt_r <= parity_on ? RX_PAR : RX_STOP;
        end
        RX_PAR: if (rxSmp) begin
          rxPar_r <= rxIn;
          rxZero_r <= rxZero_r && !rxIn;
          rxSt_r <= RX_STOP;
        end
        RX_STOP: if (rxSmp) rxSt_r <= rxIn ? RX_IDLE : RX_MARK;
        RX_MARK: if (rxIn) rxSt_r <= RX_IDLE;
        default: rxSt_r <= RX_IDLE;
      endcase
    end
  end
  ulm_fifo #(.W(11), .D(RX_DEPTH)) rxFifo (
    .clk(clk),
    .rst_n(rst_n),
    .clr(fifoClr),
    .inValid(rxPush),
    .inReady(inReady),
    .inData(rxEntry),
    .outValid(outValid),
    .outReady(rbrRd),
    .outData(head),
    .count(fifoCount)
  );
////////////////////////////////////////////////////////////////////////////////
  // line status
  wire headNew = outValid && !headRep_r;
  wire [7:0] lsrVal = {fifoMode_r && fifo_rx_error_r, tx_all_empty, !thrFull_r, bi_r, fe_r, pe_r, oe_r, outValid};
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {oe_r, pe_r, fe_r, bi_r, fifo_rx_error_r, headRep_r} <= 6'h00;
    end else begin
      headRep_r <= rbrRd ? 1'b0 : outValid;
      oe_r <= (rxDone && rxOvr) || (oe_r && !lsrRd);
      pe_r <= (headNew && head[8]) || (pe_r && !lsrRd);
      fe_r <= (headNew && head[9]) || (fe_r && !lsrRd);
      bi_r <= (headNew && head[10]) || (bi_r && !lsrRd);
      fifo_rx_error_r <= (rxPush && fifoMode_r && |rxEntry[10:8]) || (fifo_rx_error_r && !lsrRd);
    end
  end
////////////////////////////////////////////////////////////////////////////////
  // modem_input_flags and outputs
  wire [3:0] msrIn = loop ? {mcr_r[MCR_AUX_OUTPUT_B], mcr_r[MCR_AUX_OUTPUT_A], mcr_r[MCR_DTR], mcr_r[MCR_RTS]} :
    ~{dcdN, riN, dsrN, ctsN};
  wire [3:0] msrChg = msrIn ^ msrPrev_r;
  wire [7:0] msrVal = {msrIn, carrier_change_r, ring_trailing_edge_r, set_ready_change_r, clear_to_send_change_r};
  wire [5:0] trigLevel = trigSel_r == 2'b00 ? TRIG_0 : trigSel_r == 2'b01 ? TRIG_1 :
    trigSel_r == 2'b10 ? TRIG_2 : TRIG_3;
  wire rxReach = fifoMode_r ? {{(6 - CW + 6){1'b0}}, fifoCount} >= {6'h00, trigLevel} : outValid;
  wire [7:0] rdMux = selLo ? (divisor_access_select ? div_r[7:0] : head[7:0]) :
    selHi ? (divisor_access_select ? div_r[15:8] : {4'h0, ier_r}) :
    addr == ADR_IIR ? {fifoMode_r, fifoMode_r, 3'b000, rxReach && ier_r[0], 1'b0, !(rxReach && ier_r[0])} :
    addr == ADR_LCR ? lcr_r : addr == ADR_MCR ? mcr_r :
    addr == ADR_LSR ? lsrVal : addr == ADR_MSR ? msrVal : scr_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      msrPrev_r <= 4'h0;
      {clear_to_send_change_r, set_ready_change_r, ring_trailing_edge_r, carrier_change_r} <= 4'h0;
      {rtsN_r, dtrN_r, auxA_r, auxB_r} <= 4'hf;
      serialOut_r <= 1'b1;
      irq_r <= 1'b0;
      rdData_r <= RST_REG;
    end else begin
      msrPrev_r <= msrIn;
      clear_to_send_change_r <= msrChg[0] || (clear_to_send_change_r && !msrRd);
      set_ready_change_r <= msrChg[1] || (set_ready_change_r && !msrRd);
      ring_trailing_edge_r <= (msrPrev_r[2] && !msrIn[2]) || (ring_trailing_edge_r && !msrRd);
      carrier_change_r <= msrChg[3] || (carrier_change_r && !msrRd);
      rtsN_r <= loop || !mcr_r[MCR_RTS];
      dtrN_r <= loop || !mcr_r[MCR_DTR];
      auxA_r <= loop || !mcr_r[MCR_AUX_OUTPUT_A];
      auxB_r <= loop || !mcr_r[MCR_AUX_OUTPUT_B];
      serialOut_r <= !lcr_r[LCR_BRK] && (loop || txLine);
      irq_r <= ier_r[0] && rxReach;
      if (rdS) rdData_r <= rdMux;
    end
  end
  assign rdData = rdData_r;
  assign serialOutPin = serialOut_r;
  assign rtsN = rtsN_r;
  assign dtrN = dtrN_r;
  assign auxOutputAN = auxA_r;
  assign auxOutputBN = auxB_r;
  assign rxDataIrq = irq_r;
////////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_brk_space: assert property (lcr_r[LCR_BRK] |=> !serialOut_r) else $error("break not spacing");
  a_dll_route: assert property (dllWr |=> div_r[7:0] == $past(wrData)) else $error("divisor low missed");
  a_thr_clear: assert property (thrWr |=> !lsrVal[5] && !lsrVal[6]) else $error("empty flags not cleared");
  a_tx_all_empty_both: assert property ($rose(lsrVal[6]) |-> $past(txSt_r == TX_STOP)) else $error("tx_all_empty early");
  a_fifo_rx_error_char: assert property (!fifoMode_r && lsrRd |=> !rdData_r[7]) else $error("fifo error in char mode");
  a_dr_push: assert property (rxPush && !rbrRd && !fifoClr |=> lsrVal[0]) else $error("data ready missing");
  a_loop_idle: assert property (loop |=> rtsN_r && dtrN_r && auxA_r && auxB_r) else $error("loop outputs active");
  a_dtr_inv: assert property (!loop ##1 !loop |-> dtrN_r == !$past(mcr_r[MCR_DTR])) else $error("dtr not inverted");
  a_ring_trailing_edge_rise: assert property (!loop && $past(!loop) && $rose(riN) |=> ring_trailing_edge_r) else $error("ring edge missed");
  a_ovr_drop: assert property (rxDone && fifoMode_r && !inReady && !rbrRd && !fifoClr
    |=> oe_r && fifoCount == $past(fifoCount)) else $error("overrun char stored");
  a_stick_par: assert property (txLoad && stk |=> txPar_r == !$past(even_parity_choice)) else $error("stick parity wrong");
  c_rx_char: cover property (rxPush ##[1:20] rbrRd);
  c_break: cover property (rxDone && rxBreak);
  c_overrun: cover property (rxDone && rxOvr);
endmodule
